// file: shared/relay_pkg.sv
// Purpose: shared constants and types of the scan-evaluated timing relay
// Assumes: 40 MHz clock, 5 ms internal time base
// Notes: times are kept internally as counts of 5 ms ticks
package relay_pkg;
    // clock and time base
    localparam int CLOCK_NS = 25;
    localparam int TICK_MS = 5;
    localparam int TICK_CYCLES = TICK_MS * 1000000 / CLOCK_NS;
    localparam int MAX_INST = 32;
    localparam int IDX_W = 5;
    localparam int VAL_W = 20;
    localparam int TIME_W = 27;
    // setpoint limits in operand units, unit scaling against 5 ms ticks
    localparam logic [VAL_W-1:0] MAX_S_MS = 20'hf423b;
    localparam logic [VAL_W-1:0] MAX_MINSEC = 20'h0176f;
    localparam logic [TIME_W-1:0] TICKS_PER_S = 27'h00000c8;
    localparam logic [TIME_W-1:0] TICKS_PER_MIN = 27'h0002ee0;
    localparam logic [TIME_W-1:0] MS_PER_TICK = 27'h0000005;
    localparam logic [TIME_W-1:0] MIN_TICKS = 27'h0000001;
    localparam logic [15:0] LFSR_SEED = 16'hace1;
    localparam logic [15:0] LFSR_TAPS = 16'hb400;

    typedef enum logic [3:0] {
        MD_ON = 4'h0,
        MD_ON_RND = 4'h1,
        MD_OFF = 4'h2,
        MD_OFF_RND = 4'h3,
        MD_ON_OFF = 4'h4,
        MD_OFF_RTG = 4'h5,
        MD_OFF_RND_RTG = 4'h6,
        MD_ON_OFF_RND = 4'h7,
        MD_PULSE = 4'h8,
        MD_FLASH_SYNC = 4'h9,
        MD_FLASH_ASYNC = 4'ha
    } mode_t;

    typedef enum logic [1:0] {
        RNG_S = 2'h0,
        RNG_MS = 2'h1,
        RNG_HM = 2'h2
    } range_t;

    // one scan evaluation request for one timer instance
    typedef struct packed {
        logic [IDX_W-1:0] index;
        mode_t mode;
        range_t range;
        logic trigger;
        logic hold_coil;
        logic clear_coil;
        logic [VAL_W-1:0] first_setpoint;
        logic [VAL_W-1:0] second_setpoint;
    } cmd_t;

    // stored state of one timer instance
    typedef struct packed {
        logic contact;
        logic trig_prev;
        logic phase;
        logic running;
        logic [TIME_W-1:0] elapsed;
        logic [TIME_W-1:0] stamp;
        logic [TIME_W-1:0] target;
    } inst_t;

    localparam int INST_W = $bits(inst_t);
endpackage

// file: design/timer_state_mem.sv
// Purpose: per-instance state store with registered read data
// Assumes: one write and one read port on the same clock
// Notes: contents are not reset so retained values survive a reset
`timescale 1ns/1ps
module timer_state_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    // clock
    input wire logic clock,
    // write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // read port
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    // write side
    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // read data always come from a register
    always_ff @(posedge clock) begin
        rd_data <= mem[rd_addr];
    end
endmodule

// file: design/multi_mode_timing_relay.sv
// Purpose: time-multiplexed timing relay, one instance evaluated per request
// Assumes: the cyclic program issues one request per instance per scan
// Notes: elapsed time advances by the internal time base between scans
`timescale 1ns/1ps
// Operation
// - switch function selectable among on, off, on-off, random, pulse, flashing modes
// - seconds range: 0.005 to 999.995 s setpoints, 5 ms resolution
// - minutes:seconds range: 00:00 to 99:59, one second resolution
// - hours:minutes range: 00:00 to 99:59, one minute resolution
// - smallest honoured setpoint is 5 ms
// - expiry shorter than a scan is seen and acted on at next scan
// - second setpoint used only by functions needing two times
// - elapsed time shown on value output at every scan
// - clear coil zeroes elapsed time and opens the contact
// - trigger starts timing; hold coil halts running time
// - overall delay span from 5 ms up to 99 h 59 min
// - up to thirty-two independent timer instances
// - retentive timers keep elapsed value across stop and power loss
// - random modes switch after random time within the setpoint
// - retriggerable off-delay: trigger change while timing zeroes elapsed time
// - on-off delay: first setpoint on-delay, second setpoint off-delay
// - asynchronous flashing: first setpoint mark, second space; equal gives symmetry
module multi_mode_timing_relay
    import relay_pkg::*;
#(
    parameter int INSTANCES = MAX_INST,
    parameter int TICK_CYC = TICK_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // scan evaluation request
    input wire logic eval_req,
    input wire relay_pkg::cmd_t cmd,
    // retention control
    input wire logic run_start,
    input wire logic [INSTANCES-1:0] retain_mask,
    // evaluation answer
    output logic ready,
    output logic eval_done,
    output logic [relay_pkg::IDX_W-1:0] done_index,
    output logic switch_contact,
    output logic [relay_pkg::VAL_W-1:0] elapsed_value_out
);
    import relay_pkg::*;

    typedef enum logic [1:0] {
        ST_SWP_RD = 2'b00,
        ST_SWP_WR = 2'b01,
        ST_IDLE = 2'b10,
        ST_EVAL = 2'b11
    } state_t;

    state_t st_r;
    logic [IDX_W-1:0] sweep_r;
    logic [31:0] div_r;
    logic [TIME_W-1:0] now_r;
    logic [15:0] lfsr_r;
    cmd_t cmd_r;
    inst_t rd;
    inst_t nxt;
    inst_t swp;
    logic [IDX_W-1:0] rd_addr;
    logic wr_en;
    logic [IDX_W-1:0] wr_addr;
    logic [INST_W-1:0] wr_data;
    logic [TIME_W-1:0] adv;
    logic [TIME_W-1:0] sum;
    logic [TIME_W-1:0] t1;
    logic [TIME_W-1:0] t2;
    logic [TIME_W-1:0] sp1;
    logic [TIME_W-1:0] sp2;
    logic reach;
    logic rise;
    logic chg;
    logic take;

    // setpoint operand to ticks, clamped and at least one tick
    function automatic logic [TIME_W-1:0] to_ticks(range_t rg, logic [VAL_W-1:0] v);
        logic [TIME_W-1:0] t;
        logic [VAL_W-1:0] c;
        t = '0;
        c = v;
        case (rg)
            RNG_S: begin
                c = (v > MAX_S_MS) ? MAX_S_MS : v;
                t = TIME_W'((TIME_W'(c) + 27'h2) / MS_PER_TICK);
            end
            RNG_MS: begin
                c = (v > MAX_MINSEC) ? MAX_MINSEC : v;
                t = TIME_W'(TIME_W'(c) * TICKS_PER_S);
            end
            RNG_HM: begin
                c = (v > MAX_MINSEC) ? MAX_MINSEC : v;
                t = TIME_W'(TIME_W'(c) * TICKS_PER_MIN);
            end
            default: t = MIN_TICKS;
        endcase
        return (t < MIN_TICKS) ? MIN_TICKS : t;
    endfunction

    // random point within the setpoint, never below one tick
    function automatic logic [TIME_W-1:0] pick(logic [TIME_W-1:0] sp, logic [15:0] r);
        logic [TIME_W+15:0] p;
        p = (TIME_W+16)'(sp) * (TIME_W+16)'(r);
        return (p[TIME_W+15:16] < MIN_TICKS) ? MIN_TICKS : p[TIME_W+15:16];
    endfunction

    // ticks back to the unit of the time range
    function automatic logic [VAL_W-1:0] to_units(range_t rg, logic [TIME_W-1:0] e);
        case (rg)
            RNG_S: return VAL_W'(e * MS_PER_TICK);
            RNG_MS: return VAL_W'(e / TICKS_PER_S);
            RNG_HM: return VAL_W'(e / TICKS_PER_MIN);
            default: return '0;
        endcase
    endfunction

    // 5 ms time base: divider enable advances the scan timestamp
    always_ff @(posedge clock) begin
        if (rst) begin
            div_r <= '0;
            now_r <= '0;
        end else if (div_r == 32'(TICK_CYC - 1)) begin
            div_r <= '0;
            now_r <= now_r + 27'h1;
        end else begin
            div_r <= div_r + 32'h1;
        end
    end

    // free-running random source for the random modes
    always_ff @(posedge clock) begin
        if (rst) begin
            lfsr_r <= LFSR_SEED;
        end else begin
            lfsr_r <= {1'b0, lfsr_r[15:1]} ^ (lfsr_r[0] ? LFSR_TAPS : 16'h0000);
        end
    end

    assign take = eval_req && !run_start && (32'(cmd.index) < INSTANCES);

    // state sequencing: sweep after reset or run start, then serve requests
    always_ff @(posedge clock) begin
        if (rst) begin
            st_r <= ST_SWP_RD;
            sweep_r <= '0;
            cmd_r <= '0;
        end else begin
            case (st_r)
                ST_SWP_RD: st_r <= ST_SWP_WR;
                ST_SWP_WR: begin
                    if (32'(sweep_r) == INSTANCES - 1) begin
                        st_r <= ST_IDLE;
                        sweep_r <= '0;
                    end else begin
                        st_r <= ST_SWP_RD;
                        sweep_r <= sweep_r + 5'h1;
                    end
                end
                ST_IDLE: begin
                    if (run_start) begin
                        st_r <= ST_SWP_RD;
                    end else if (take) begin
                        st_r <= ST_EVAL;
                        cmd_r <= cmd;
                    end
                end
                ST_EVAL: st_r <= ST_IDLE;
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // instance state lives in its own memory, one word per timer
    assign rd_addr = (st_r == ST_IDLE) ? cmd.index : sweep_r;
    timer_state_mem #(.WIDTH(INST_W), .DEPTH(INSTANCES), .AW(IDX_W)) timer_state_mem_inst (
        .clock(clock),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(rd_addr),
        .rd_data(rd)
    );

    // sweep keeps retentive words, restamped so the stop time is not counted
    always_comb begin
        swp = '0;
        if (retain_mask[sweep_r]) begin
            swp = rd;
            swp.stamp = now_r;
        end
    end

    assign wr_en = (st_r == ST_SWP_WR) || (st_r == ST_EVAL);
    assign wr_addr = (st_r == ST_EVAL) ? cmd_r.index : sweep_r;
    assign wr_data = (st_r == ST_EVAL) ? nxt : swp;

    // shared terms: time since last scan, halted while hold is active
    always_comb begin
        sp1 = to_ticks(cmd_r.range, cmd_r.first_setpoint);
        sp2 = to_ticks(cmd_r.range, cmd_r.second_setpoint);
        t1 = cmd_r.mode inside {MD_ON_RND, MD_OFF_RND, MD_OFF_RND_RTG, MD_ON_OFF_RND} ?
             pick(sp1, lfsr_r) : sp1;
        t2 = (cmd_r.mode == MD_ON_OFF_RND) ? pick(sp2, lfsr_r) : sp2;
        adv = cmd_r.hold_coil ? '0 : TIME_W'(now_r - rd.stamp);
        sum = rd.elapsed + adv;
        reach = sum >= rd.target;
        rise = cmd_r.trigger && !rd.trig_prev;
        chg = cmd_r.trigger != rd.trig_prev;
    end

    // next state of the evaluated instance
    always_comb begin
        nxt = rd;
        nxt.stamp = now_r;
        nxt.trig_prev = cmd_r.trigger;
        if (cmd_r.clear_coil) begin
            nxt.contact = 1'b0;
            nxt.phase = 1'b0;
            nxt.running = 1'b0;
            nxt.elapsed = '0;
        end else begin
            case (cmd_r.mode)
                MD_ON, MD_ON_RND, MD_ON_OFF, MD_ON_OFF_RND: begin
                    if (rd.phase) begin
                        // off-delay half of the on-off function
                        if (cmd_r.trigger) begin
                            nxt.running = 1'b0;
                            nxt.elapsed = '0;
                        end else if (!rd.running) begin
                            nxt.running = 1'b1;
                            nxt.elapsed = '0;
                            nxt.target = t2;
                        end else if (reach) begin
                            nxt.contact = 1'b0;
                            nxt.phase = 1'b0;
                            nxt.running = 1'b0;
                            nxt.elapsed = rd.target;
                        end else begin
                            nxt.elapsed = sum;
                        end
                    end else if (!cmd_r.trigger) begin
                        nxt.contact = 1'b0;
                        nxt.running = 1'b0;
                        nxt.elapsed = '0;
                    end else if (rd.contact) begin
                        nxt.running = 1'b0; // elapsed, hold has no effect now
                    end else if (!rd.running) begin
                        nxt.running = 1'b1;
                        nxt.elapsed = '0;
                        nxt.target = t1;
                    end else if (reach) begin
                        nxt.contact = 1'b1;
                        nxt.running = 1'b0;
                        nxt.elapsed = rd.target;
                        nxt.phase = cmd_r.mode inside {MD_ON_OFF, MD_ON_OFF_RND};
                    end else begin
                        nxt.elapsed = sum;
                    end
                end
                MD_OFF, MD_OFF_RND, MD_OFF_RTG, MD_OFF_RND_RTG: begin
                    if (cmd_r.trigger) begin
                        nxt.contact = 1'b1;
                        if (!rd.running || !rd.contact) begin
                            nxt.elapsed = '0;
                            nxt.running = 1'b0;
                        end else if (chg && cmd_r.mode inside {MD_OFF_RTG, MD_OFF_RND_RTG}) begin
                            nxt.elapsed = '0;
                        end
                    end else if (rd.contact) begin
                        if (!rd.running) begin
                            nxt.running = 1'b1;
                            nxt.elapsed = '0;
                            nxt.target = t1;
                        end else if (chg && cmd_r.mode inside {MD_OFF_RTG, MD_OFF_RND_RTG}) begin
                            nxt.elapsed = '0;
                            nxt.target = t1;
                        end else if (reach) begin
                            nxt.contact = 1'b0;
                            nxt.running = 1'b0;
                            nxt.elapsed = rd.target;
                        end else begin
                            nxt.elapsed = sum;
                        end
                    end
                end
                MD_PULSE: begin
                    if (rd.running) begin
                        // runs on regardless of the trigger level
                        if (reach) begin
                            nxt.contact = 1'b0;
                            nxt.running = 1'b0;
                            nxt.elapsed = rd.target;
                        end else begin
                            nxt.elapsed = sum;
                        end
                    end else if (rise) begin
                        nxt.contact = 1'b1;
                        nxt.running = 1'b1;
                        nxt.elapsed = '0;
                        nxt.target = t1;
                    end
                end
                MD_FLASH_SYNC, MD_FLASH_ASYNC: begin
                    if (!cmd_r.trigger) begin
                        nxt.contact = 1'b0;
                        nxt.phase = 1'b0;
                        nxt.running = 1'b0;
                        nxt.elapsed = '0;
                    end else if (!rd.running) begin
                        nxt.contact = 1'b1;
                        nxt.phase = 1'b0;
                        nxt.running = 1'b1;
                        nxt.elapsed = '0;
                        nxt.target = t1;
                    end else if (reach) begin
                        nxt.phase = !rd.phase;
                        nxt.contact = rd.phase;
                        nxt.elapsed = '0;
                        nxt.target = (rd.phase || cmd_r.mode == MD_FLASH_SYNC) ? t1 : t2;
                    end else begin
                        nxt.elapsed = sum;
                    end
                end
                default: nxt = rd; // unused codes leave the instance untouched
            endcase
        end
    end

    // answer registers: every output straight from a flip-flop
    always_ff @(posedge clock) begin
        if (rst) begin
            ready <= 1'b0;
            eval_done <= 1'b0;
            done_index <= '0;
            switch_contact <= 1'b0;
            elapsed_value_out <= '0;
        end else begin
            ready <= (st_r == ST_IDLE) ? !(run_start || take) : (st_r == ST_EVAL);
            eval_done <= (st_r == ST_EVAL);
            if (st_r == ST_EVAL) begin
                done_index <= cmd_r.index;
                switch_contact <= nxt.contact;
                elapsed_value_out <= to_units(cmd_r.range, nxt.elapsed);
            end
        end
    end

    done_latency_a: assert property (@(posedge clock) disable iff (rst)
        (st_r == ST_IDLE && take && !run_start) |=> !eval_done ##1 eval_done)
        else $error("evaluation answer not two cycles after request");
    clear_opens_a: assert property (@(posedge clock) disable iff (rst)
        (st_r == ST_IDLE && take && cmd.clear_coil) |=> ##1
        (!switch_contact && elapsed_value_out == '0))
        else $error("clear did not open contact and zero time");
    on_release_a: assert property (@(posedge clock) disable iff (rst)
        (st_r == ST_IDLE && take && cmd.mode == MD_ON && !cmd.trigger) |=> ##1
        !switch_contact)
        else $error("on-delay contact closed without trigger");
    off_closes_a: assert property (@(posedge clock) disable iff (rst)
        (st_r == ST_IDLE && take && cmd.mode == MD_OFF && cmd.trigger
        && !cmd.clear_coil) |=> ##1 switch_contact)
        else $error("off-delay contact open with trigger");
    pulse_edge_a: assert property (@(posedge clock) disable iff (rst)
        (st_r == ST_EVAL && cmd_r.mode == MD_PULSE && !cmd_r.clear_coil
        && rise && !rd.running) |=> switch_contact)
        else $error("pulse edge did not close contact");
    tick_rate_a: assert property (@(posedge clock) disable iff (rst)
        ($changed(now_r) && !$past(rst)) |-> $past(div_r) == 32'(TICK_CYC - 1))
        else $error("time base advanced off the divider count");
    min_setpoint_a: assert property (@(posedge clock) disable iff (rst)
        (st_r == ST_EVAL) |-> (t1 >= MIN_TICKS && t2 >= MIN_TICKS))
        else $error("setpoint below one tick");
    hold_freeze_a: assert property (@(posedge clock) disable iff (rst)
        (st_r == ST_EVAL && cmd_r.hold_coil && !cmd_r.clear_coil && rd.running
        && nxt.running && !(cmd_r.mode inside {MD_OFF_RTG, MD_OFF_RND_RTG}))
        |-> nxt.elapsed == rd.elapsed)
        else $error("elapsed time moved while held");
    retrig_zero_a: assert property (@(posedge clock) disable iff (rst)
        (st_r == ST_EVAL && cmd_r.mode == MD_OFF_RTG && !cmd_r.clear_coil
        && rd.running && rd.contact && chg) |-> nxt.elapsed == '0)
        else $error("retrigger did not zero elapsed time");
endmodule

// file: verification/coil_program.sv
// Purpose: model of the cyclic program that scans the timer instances
// Assumes: requests change only at the falling clock edge
// Notes: released command lines carry the inverted last command, never a stale copy
`timescale 1ns/1ps
module coil_program
    import relay_pkg::*;
(
    // clock
    input wire logic clock,
    // answer from the relay
    input wire logic ready,
    input wire logic eval_done,
    // scan request
    output logic eval_req,
    output relay_pkg::cmd_t cmd
);
    initial begin
        eval_req = 1'b0;
        cmd = '0;
    end

    // one scan: request held through the taking edge, then the answer is awaited
    task automatic scan(input cmd_t c, output int lat);
        lat = 0;
        while (ready !== 1'b1 && lat < 200) begin
            @(negedge clock);
            lat++;
        end
        eval_req = 1'b1;
        cmd = c;
        @(posedge clock);
        @(negedge clock);
        eval_req = 1'b0;
        cmd = cmd_t'(~c);  // so a late sample cannot see the old command
        lat = 1;
        while (eval_done !== 1'b1 && lat < 8) begin
            @(negedge clock);
            lat++;
        end
    endtask
endmodule

// file: verification/multi_mode_timing_relay_test.sv
// Purpose: self-checking bench for the scan-evaluated timing relay
// Assumes: time base shortened to 4 clocks per 5 ms tick
// Notes: waits leave a margin of a tick either side of each expiry
`timescale 1ns/1ps
module multi_mode_timing_relay_test;
    import relay_pkg::*;
    localparam logic [VAL_W-1:0] ANY = 20'hfffff;
    localparam logic [10:0] FIRST = 11'h76c;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic run_start = 1'b0;
    logic [MAX_INST-1:0] retain_mask = '0;
    logic eval_req, ready, eval_done, switch_contact;
    cmd_t cmd;
    logic [IDX_W-1:0] done_index;
    logic [VAL_W-1:0] elapsed_value_out, kept;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    // 40 MHz
    always #12.5 clock = ~clock;

    multi_mode_timing_relay #(.INSTANCES(MAX_INST), .TICK_CYC(4)) multi_mode_timing_relay_inst (
        .clock(clock), .rst(rst), .eval_req(eval_req), .cmd(cmd), .run_start(run_start),
        .retain_mask(retain_mask), .ready(ready), .eval_done(eval_done),
        .done_index(done_index), .switch_contact(switch_contact),
        .elapsed_value_out(elapsed_value_out));
    coil_program coil_program_inst (.clock(clock), .ready(ready), .eval_done(eval_done),
        .eval_req(eval_req), .cmd(cmd));

    task automatic stop_test();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic ok(input logic good);
        comparisons++;
        if (good !== 1'b1) begin
            num_errors++;
            $display("Error at %0t: contact %b value %0d index %0d", $time, switch_contact,
                elapsed_value_out, done_index);
        end
    endtask

    task automatic wt(input int k);
        repeat (k) @(negedge clock);
    endtask

    // a sweep keeps the relay busy for two cycles per instance
    task automatic wait_ready();
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 80) begin
            @(negedge clock);
            n++;
        end
        ok(ready === 1'b1 && n >= 60);
    endtask

    // one scan of instance i, then contact k and value v expected (v may be ANY)
    task automatic sc(input logic [IDX_W-1:0] i, input mode_t m, input logic t,
        input logic k, input logic [VAL_W-1:0] v, input logic h = 1'b0,
        input logic cl = 1'b0, input logic [VAL_W-1:0] s1 = 20'h00032,
        input range_t r = RNG_S);
        cmd_t c;
        int lat;
        logic good;
        c = '{index: i, mode: m, range: r, trigger: t, hold_coil: h, clear_coil: cl,
            first_setpoint: s1, second_setpoint: 20'h00001};
        coil_program_inst.scan(c, lat);
        good = switch_contact === k && (v === ANY || elapsed_value_out === v);
        ok(good && lat == 2 && done_index === i);
    endtask

    // hang guard, well above the longest sequence
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            num_errors++;
            $display("Error at %0t: timeout", $time);
            stop_test();
        end
    end

    initial begin
        wt(6);
        ok(switch_contact === 1'b0 && elapsed_value_out === 20'h0 && ready === 1'b0);
        rst = 1'b0;
        wait_ready();
        // on-delay on the last instance: hold, independence, expiry, release, clear
        sc(31, MD_ON, 1'b1, 1'b0, 20'h0);
        wt(16);
        sc(31, MD_ON, 1'b1, 1'b0, ANY);
        wt(100);
        sc(31, MD_ON, 1'b1, 1'b0, ANY, 1'b1);  // hold drops the time
        sc(0, MD_OFF, 1'b0, 1'b0, 20'h0);
        wt(60);
        sc(31, MD_ON, 1'b1, 1'b1, 20'h00032);
        sc(31, MD_ON, 1'b0, 1'b0, 20'h0);
        sc(31, MD_ON, 1'b1, 1'b0, 20'h0);
        wt(16);
        sc(31, MD_ON, 1'b0, 1'b0, 20'h0);  // early release
        sc(31, MD_ON, 1'b1, 1'b0, 20'h0);
        wt(60);
        sc(31, MD_ON, 1'b1, 1'b0, 20'h0, 1'b0, 1'b1);
        // smallest setpoint, shorter than the scan spacing
        sc(30, MD_ON, 1'b1, 1'b0, 20'h0, 1'b0, 1'b0, 20'h00005);
        wt(8);
        sc(30, MD_ON, 1'b1, 1'b1, 20'h00005, 1'b0, 1'b0, 20'h00005);
        // off-delay, second setpoint of 5 ms must not shorten it
        sc(1, MD_OFF, 1'b1, 1'b1, ANY);
        sc(1, MD_OFF, 1'b0, 1'b1, 20'h0);
        wt(20);
        sc(1, MD_OFF, 1'b0, 1'b1, ANY);
        wt(40);
        sc(1, MD_OFF, 1'b0, 1'b0, 20'h00032);
        // retriggered off-delay restarts from zero
        sc(6, MD_OFF_RTG, 1'b1, 1'b1, ANY);
        sc(6, MD_OFF_RTG, 1'b0, 1'b1, 20'h0);
        wt(24);
        sc(6, MD_OFF_RTG, 1'b1, 1'b1, ANY);
        sc(6, MD_OFF_RTG, 1'b0, 1'b1, 20'h0);
        wt(24);
        sc(6, MD_OFF_RTG, 1'b0, 1'b1, ANY);
        // pulse lengthens a short trigger and cuts a long one
        sc(2, MD_PULSE, 1'b1, 1'b1, ANY);
        sc(2, MD_PULSE, 1'b0, 1'b1, ANY);
        wt(60);
        sc(2, MD_PULSE, 1'b0, 1'b0, ANY);
        sc(2, MD_PULSE, 1'b1, 1'b1, ANY);
        wt(60);
        sc(2, MD_PULSE, 1'b1, 1'b0, ANY);
        // every switch function once, then all of them again after the setpoint
        for (int k = 0; k < 11; k++) begin
            sc(IDX_W'(8 + k), mode_t'(k), 1'b1, FIRST[k], 20'h0);
        end
        wt(44);
        for (int k = 0; k < 11; k++) begin
            sc(IDX_W'(8 + k), mode_t'(k), 1'b1, k < 8, ANY);
        end
        sc(12, MD_ON_OFF, 1'b0, 1'b1, 20'h0);
        wt(12);
        sc(12, MD_ON_OFF, 1'b0, 1'b0, 20'h00005);
        sc(17, MD_FLASH_SYNC, 1'b1, 1'b0, ANY);  // space as long as the mark
        sc(18, MD_FLASH_ASYNC, 1'b1, 1'b1, ANY);  // short space already over
        // retention across a restart sweep
        sc(5, MD_ON, 1'b1, 1'b0, 20'h0);
        wt(16);
        sc(5, MD_ON, 1'b1, 1'b0, ANY);  // nonzero time to be kept
        kept = elapsed_value_out;
        retain_mask = 32'h00000020;
        run_start = 1'b1;
        wt(1);
        run_start = 1'b0;
        wait_ready();
        sc(5, MD_ON, 1'b1, 1'b0, kept, 1'b1);
        sc(1, MD_OFF, 1'b0, 1'b0, 20'h0, 1'b1);
        // longer ranges count in seconds and minutes
        sc(3, MD_ON, 1'b1, 1'b0, 20'h0, 1'b0, 1'b0, 20'h00001, RNG_MS);
        wt(820);
        sc(3, MD_ON, 1'b1, 1'b1, 20'h00001, 1'b0, 1'b0, 20'h00001, RNG_MS);
        sc(4, MD_ON, 1'b1, 1'b0, 20'h0, 1'b0, 1'b0, 20'h00001, RNG_HM);
        wt(47000);
        sc(4, MD_ON, 1'b1, 1'b0, ANY, 1'b0, 1'b0, 20'h00001, RNG_HM);
        wt(1200);
        sc(4, MD_ON, 1'b1, 1'b1, 20'h00001, 1'b0, 1'b0, 20'h00001, RNG_HM);
        stop_test();
    end
endmodule
